// ==== hdl/switch_lookup_cfg.svh ====
// Offsets, field positions, reset values and fixed counts of the lookup config bank
// Assumes inclusion by bare name from the design files
`ifndef SWITCH_LOOKUP_CFG_SVH
`define SWITCH_LOOKUP_CFG_SVH

// Register indexes; byte address is four times the index
`define SLC_IDX_SHAPER 12'h30E
`define SLC_IDX_LOOKUP0 12'h310
`define SLC_ADDR_W 14

// Shaper strategy fields
`define SLC_SHAPE_ACCT_BIT 1
`define SLC_POLICE_ACCT_BIT 0
`define SLC_SHAPER_RST 2'h3

// Lookup control zero fields and reset value
`define SLC_VLAN_EN_BIT 7
`define SLC_DROP_VID_BIT 6
`define SLC_AGE_MSB 5
`define SLC_AGE_LSB 3
`define SLC_RSVD_MC_BIT 2
`define SLC_HASH_MSB 1
`define SLC_HASH_LSB 0
`define SLC_LOOKUP0_RST 8'h61

// Interpacket gap plus preamble, in bytes
`define SLC_IPG_BYTES 12
`define SLC_PREAMBLE_BYTES 8

// Hash constants
`define SLC_INDEX_W 10
`define SLC_CRC_POLY 10'h233
`define SLC_CRC_INIT 10'h3FF

`endif

// ==== hdl/switch_lookup_pkg.sv ====
// Types shared by the lookup config bank and its helpers
// Assumes switch_lookup_cfg.svh is on the include path
`include "switch_lookup_cfg.svh"

package switch_lookup_pkg;

  typedef enum logic [1:0] {
    HASH_DIRECT = 2'b00,
    HASH_CRC = 2'b01,
    HASH_XOR = 2'b10,
    HASH_DIRECT_ALT = 2'b11
  } hash_sel_e;

  typedef logic [47:0] mac_addr_t;
  typedef logic [`SLC_INDEX_W-1:0] table_index_t;

  typedef struct packed {
    logic vlanEnable;
    logic dropInvalidVid;
    logic [2:0] ageCount;
    logic rsvdMcastEnable;
    hash_sel_e hashSelect;
  } lookup_ctrl_s;

endpackage

// ==== hdl/lookup_index_if.sv ====
// Request and answer of the dynamic table index computation
// Assumes one clock shared by both ends
interface lookup_index_if;
  import switch_lookup_pkg::*;

  logic lookupValid;
  mac_addr_t destAddr;
  hash_sel_e hashSelect;
  logic indexValid;
  table_index_t tableIndex;

  modport requester (output lookupValid, output destAddr, output hashSelect,
                     input indexValid, input tableIndex);
  modport hasher (input lookupValid, input destAddr, input hashSelect,
                  output indexValid, output tableIndex);
endinterface

// ==== hdl/credit_charge.sv ====
// Byte count charged against a credit bucket for one frame
// Assumes frame length and strobe come from logic on clk_sys
module credit_charge
  import switch_lookup_pkg::*;
#(
  parameter int LEN_W = 16,
  parameter int OVERHEAD = `SLC_IPG_BYTES + `SLC_PREAMBLE_BYTES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic withOverhead,
  input wire logic frameValid,
  input wire logic [LEN_W-1:0] frameLen,
  output logic chargeValid,
  output logic [LEN_W:0] chargeBytes
);

  if (LEN_W < 6 || OVERHEAD < 0 || OVERHEAD >= (1 << LEN_W)) begin : gBadParams
    $error("credit_charge: unsupported LEN_W or OVERHEAD");
  end

  localparam logic [LEN_W:0] EXTRA = (LEN_W+1)'(OVERHEAD);

  typedef struct packed {
    logic chargeValid;
    logic [LEN_W:0] chargeBytes;
  } charge_state_s;

  charge_state_s state;
  charge_state_s next_state;

  always_comb begin
    next_state = state;
    next_state.chargeValid = frameValid;
    if (frameValid) begin
      next_state.chargeBytes = {1'b0, frameLen} + (withOverhead ? EXTRA : '0);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign chargeValid = state.chargeValid;
  assign chargeBytes = state.chargeBytes;

endmodule

// ==== hdl/dynamic_index_hash.sv ====
// Maps a destination address to a dynamic address table index
// Assumes requests arrive on clk_sys through lookup_index_if
module dynamic_index_hash
  import switch_lookup_pkg::*;
#(
  parameter logic [`SLC_INDEX_W-1:0] CRC_POLY = `SLC_CRC_POLY,
  parameter logic [`SLC_INDEX_W-1:0] CRC_INIT = `SLC_CRC_INIT
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  lookup_index_if.hasher lk
);

  if (CRC_POLY[0] != 1'b1) begin : gBadPoly
    $error("dynamic_index_hash: CRC_POLY needs its constant term");
  end

  function automatic table_index_t crcHash(input mac_addr_t addr);
    table_index_t crc;
    logic fb;
    crc = CRC_INIT;
    for (int i = 47; i >= 0; i--) begin
      fb = crc[`SLC_INDEX_W-1] ^ addr[i];
      crc = {crc[`SLC_INDEX_W-2:0], 1'b0};
      if (fb) begin
        crc = crc ^ CRC_POLY;
      end
    end
    return crc;
  endfunction

  function automatic table_index_t xorHash(input mac_addr_t addr);
    logic [49:0] padded;
    table_index_t acc;
    padded = {2'b00, addr};
    acc = '0;
    for (int i = 0; i < 5; i++) begin
      acc = acc ^ padded[i*`SLC_INDEX_W +: `SLC_INDEX_W];
    end
    return acc;
  endfunction

  typedef struct packed {
    logic indexValid;
    table_index_t tableIndex;
  } hash_state_s;

  hash_state_s state;
  hash_state_s next_state;

  always_comb begin
    next_state = state;
    next_state.indexValid = lk.lookupValid;
    if (lk.lookupValid) begin
      case (lk.hashSelect)
        HASH_CRC: next_state.tableIndex = crcHash(lk.destAddr); // RQ11
        HASH_XOR: next_state.tableIndex = xorHash(lk.destAddr); // RQ12
        default: next_state.tableIndex = lk.destAddr[`SLC_INDEX_W-1:0]; // RQ10
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign lk.indexValid = state.indexValid;
  assign lk.tableIndex = state.tableIndex;

endmodule

// ==== hdl/switch_lookup_shaper_config.sv ====
// Shaper strategy and lookup control zero registers with the logic they steer
// Assumes an APB master on clk_sys and frame, VLAN and table strobes from clk_sys logic
// Function
// RQ1: Shaper charges overhead when its bit set
// RQ2: Policer charges overhead when its bit set
// RQ3: VLAN master enable, reset off
// RQ4: Software programs VLAN table before enabling
// RQ5: Invalid VID dropped or sent to host
// RQ6: Unknown-VID forwarding overrides the drop bit
// RQ7: Age count loaded on dynamic entry update
// RQ8: Aging time from age count and period
// RQ9: Reserved multicast table enable, reset off
// RQ10: Hash select 00/11 uses low ten bits
// RQ11: Hash select 01 uses CRC hash
// RQ12: Hash select 10 uses XOR hash
// RQ13: Shaper register reserved bits read zero
module switch_lookup_shaper_config
  import switch_lookup_pkg::*;
#(
  parameter int LEN_W = 16,
  parameter int PERIOD_W = 8
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`SLC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic shapeFrameValid,
  input wire logic [LEN_W-1:0] shapeFrameLen,
  output logic shapeChargeValid,
  output logic [LEN_W:0] shapeCharge,
  input wire logic policeFrameValid,
  input wire logic [LEN_W-1:0] policeFrameLen,
  output logic policeChargeValid,
  output logic [LEN_W:0] policeCharge,
  input wire logic vidCheckValid,
  input wire logic vidInvalid,
  input wire logic unknownVidFwdEnable,
  output logic vlanEnable,
  output logic vidDecisionValid,
  output logic vidDrop,
  output logic vidToHost,
  output logic vidUnknownFwd,
  input wire logic dynEntryUpdate,
  input wire logic [PERIOD_W-1:0] agePeriod,
  output logic ageLoadValid,
  output logic [2:0] ageLoadValue,
  output logic [PERIOD_W+2:0] agingTime,
  output logic rsvdMcastEnable,
  input wire logic lookupValid,
  input wire mac_addr_t destAddr,
  output logic indexValid,
  output table_index_t tableIndex
);

  // Refuse widths the charge and aging arithmetic cannot hold
  if (LEN_W < 6 || LEN_W > 31 || PERIOD_W < 1 || PERIOD_W > 24) begin : gBadParams
    $error("switch_lookup_shaper_config: unsupported LEN_W or PERIOD_W");
  end

  localparam logic [`SLC_ADDR_W-1:0] ADDR_SHAPER = {`SLC_IDX_SHAPER, 2'b00};
  localparam logic [`SLC_ADDR_W-1:0] ADDR_LOOKUP0 = {`SLC_IDX_LOOKUP0, 2'b00};

  typedef enum logic [1:0] {
    SEL_NONE = 2'b00,
    SEL_SHAPER = 2'b01,
    SEL_LOOKUP0 = 2'b10
  } reg_sel_e;

  function automatic reg_sel_e decodeAddr(input logic [`SLC_ADDR_W-1:0] addr);
    if (addr == ADDR_SHAPER) begin
      return SEL_SHAPER;
    end else if (addr == ADDR_LOOKUP0) begin
      return SEL_LOOKUP0;
    end
    return SEL_NONE;
  endfunction

  typedef struct packed {
    logic shapeAcct;
    logic policeAcct;
    lookup_ctrl_s ctrl;
    logic [31:0] readData;
    logic decValid;
    logic drop;
    logic toHost;
    logic unknownFwd;
    logic ageValid;
    logic [2:0] ageValue;
    logic [PERIOD_W+2:0] agingTime;
  } cfg_state_s;

  localparam lookup_ctrl_s CTRL_RST = lookup_ctrl_s'(`SLC_LOOKUP0_RST);
  localparam logic [1:0] SHAPER_RST = `SLC_SHAPER_RST;

  cfg_state_s state;
  cfg_state_s next_state;
  reg_sel_e sel;
  logic setupPhase;
  logic writeAccess;

  assign sel = decodeAddr(paddr);
  assign setupPhase = psel && !penable;
  assign writeAccess = psel && penable && pwrite;

  always_comb begin
    next_state = state;
    // Read data prepared at setup so it is steady in the access phase
    if (setupPhase) begin
      next_state.readData = '0;
      case (sel)
        SEL_SHAPER: begin
          next_state.readData[`SLC_SHAPE_ACCT_BIT] = state.shapeAcct;
          next_state.readData[`SLC_POLICE_ACCT_BIT] = state.policeAcct; // RQ13
        end
        SEL_LOOKUP0: next_state.readData[7:0] = state.ctrl;
        default: next_state.readData = '0;
      endcase
    end
    // Only the defined bits store; the rest of the word is dropped
    if (writeAccess && pstrb[0]) begin
      case (sel)
        SEL_SHAPER: begin
          next_state.shapeAcct = pwdata[`SLC_SHAPE_ACCT_BIT];
          next_state.policeAcct = pwdata[`SLC_POLICE_ACCT_BIT]; // RQ13
        end
        SEL_LOOKUP0: begin
          next_state.ctrl.vlanEnable = pwdata[`SLC_VLAN_EN_BIT]; // RQ3
          next_state.ctrl.dropInvalidVid = pwdata[`SLC_DROP_VID_BIT];
          next_state.ctrl.ageCount = pwdata[`SLC_AGE_MSB:`SLC_AGE_LSB];
          next_state.ctrl.rsvdMcastEnable = pwdata[`SLC_RSVD_MC_BIT]; // RQ9
          next_state.ctrl.hashSelect = hash_sel_e'(pwdata[`SLC_HASH_MSB:`SLC_HASH_LSB]);
        end
        default: next_state.ctrl = state.ctrl;
      endcase
    end

    // Invalid VID handling; filtering is idle while VLAN mode is off
    next_state.decValid = vidCheckValid;
    next_state.drop = 1'b0;
    next_state.toHost = 1'b0;
    next_state.unknownFwd = 1'b0;
    if (vidCheckValid && vidInvalid && state.ctrl.vlanEnable) begin // RQ3
      if (unknownVidFwdEnable) begin
        next_state.unknownFwd = 1'b1; // RQ6
      end else if (state.ctrl.dropInvalidVid) begin
        next_state.drop = 1'b1; // RQ5
      end else begin
        next_state.toHost = 1'b1; // RQ5
      end
    end

    // Age counter value handed to the table engine on each update
    next_state.ageValid = dynEntryUpdate;
    if (dynEntryUpdate) begin
      next_state.ageValue = state.ctrl.ageCount; // RQ7
    end
    next_state.agingTime = {{PERIOD_W{1'b0}}, state.ctrl.ageCount} * {3'b000, agePeriod}; // RQ8
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
      state.shapeAcct <= SHAPER_RST[`SLC_SHAPE_ACCT_BIT];
      state.policeAcct <= SHAPER_RST[`SLC_POLICE_ACCT_BIT];
      state.ctrl <= CTRL_RST;
    end else begin
      state <= next_state;
    end
  end

  // Zero-wait slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = psel && penable && (sel == SEL_NONE);
  assign prdata = state.readData;

  assign vlanEnable = state.ctrl.vlanEnable; // RQ3
  assign rsvdMcastEnable = state.ctrl.rsvdMcastEnable; // RQ9
  assign vidDecisionValid = state.decValid;
  assign vidDrop = state.drop;
  assign vidToHost = state.toHost;
  assign vidUnknownFwd = state.unknownFwd;
  assign ageLoadValid = state.ageValid;
  assign ageLoadValue = state.ageValue;
  assign agingTime = state.agingTime;

  credit_charge #(
    .LEN_W(LEN_W),
    .OVERHEAD(`SLC_IPG_BYTES + `SLC_PREAMBLE_BYTES)
  ) shaperCharge (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .withOverhead(state.shapeAcct), // RQ1
    .frameValid(shapeFrameValid),
    .frameLen(shapeFrameLen),
    .chargeValid(shapeChargeValid),
    .chargeBytes(shapeCharge)
  );

  credit_charge #(
    .LEN_W(LEN_W),
    .OVERHEAD(`SLC_IPG_BYTES + `SLC_PREAMBLE_BYTES)
  ) policerCharge (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .withOverhead(state.policeAcct), // RQ2
    .frameValid(policeFrameValid),
    .frameLen(policeFrameLen),
    .chargeValid(policeChargeValid),
    .chargeBytes(policeCharge)
  );

  lookup_index_if lk ();

  assign lk.lookupValid = lookupValid;
  assign lk.destAddr = destAddr;
  assign lk.hashSelect = state.ctrl.hashSelect; // RQ10

  dynamic_index_hash #(
    .CRC_POLY(`SLC_CRC_POLY),
    .CRC_INIT(`SLC_CRC_INIT)
  ) indexHash (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .lk(lk)
  );

  assign indexValid = lk.indexValid;
  assign tableIndex = lk.tableIndex;

endmodule

// ==== dv/switch_lookup_shaper_config_chk.sv ====
// Concurrent checks on the lookup config bank top ports
// Assumes one clock, async active-low reset, byte addresses from the header
`include "switch_lookup_cfg.svh"
module switch_lookup_shaper_config_chk
  import switch_lookup_pkg::*;
#(
  parameter int LEN_W = 16,
  parameter int PERIOD_W = 8
) (
  input logic clk_sys,
  input logic rst_n,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [`SLC_ADDR_W-1:0] paddr,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  input logic [31:0] prdata,
  input logic shapeFrameValid,
  input logic [LEN_W-1:0] shapeFrameLen,
  input logic shapeChargeValid,
  input logic [LEN_W:0] shapeCharge,
  input logic policeFrameValid,
  input logic [LEN_W-1:0] policeFrameLen,
  input logic policeChargeValid,
  input logic [LEN_W:0] policeCharge,
  input logic vidCheckValid,
  input logic vidInvalid,
  input logic unknownVidFwdEnable,
  input logic vlanEnable,
  input logic vidDecisionValid,
  input logic vidDrop,
  input logic vidToHost,
  input logic vidUnknownFwd,
  input logic dynEntryUpdate,
  input logic [PERIOD_W-1:0] agePeriod,
  input logic ageLoadValid,
  input logic [2:0] ageLoadValue,
  input logic [PERIOD_W+2:0] agingTime,
  input logic lookupValid,
  input mac_addr_t destAddr,
  input logic indexValid,
  input table_index_t tableIndex
);
  localparam logic [13:0] A_SH = {`SLC_IDX_SHAPER, 2'b00};
  localparam logic [13:0] A_LK = {`SLC_IDX_LOOKUP0, 2'b00};
  localparam int OV = `SLC_IPG_BYTES + `SLC_PREAMBLE_BYTES;
  logic [1:0] shp;
  logic [7:0] lk;
  wire logic wr = psel && penable && pwrite && pstrb[0];
  // Shadow of the two registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      shp <= `SLC_SHAPER_RST;
      lk <= `SLC_LOOKUP0_RST;
    end else if (wr && paddr == A_SH) begin
      shp <= pwdata[1:0];
    end else if (wr && paddr == A_LK) begin
      lk <= pwdata[7:0];
    end
  end
  function automatic table_index_t crc(mac_addr_t a);
    table_index_t c;
    c = `SLC_CRC_INIT;
    for (int i = 47; i >= 0; i--) begin
      c = (c[9] ^ a[i]) ? ((c << 1) ^ `SLC_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_SHAPE: assert property (shapeFrameValid |=> shapeChargeValid &&
    shapeCharge == $past(shapeFrameLen) + ($past(shp[1]) ? OV : 0)) else $error("shaper charge wrong");
  AST_POLICE: assert property (policeFrameValid |=> policeChargeValid &&
    policeCharge == $past(policeFrameLen) + ($past(shp[0]) ? OV : 0)) else $error("policer charge wrong");
  AST_VLAN_WR: assert property (wr && paddr == A_LK |=>
    vlanEnable == $past(pwdata[7])) else $error("vlan enable not taken");
  AST_VID_DROP: assert property (vidCheckValid && vlanEnable && vidInvalid && !unknownVidFwdEnable |=>
    vidDecisionValid && vidDrop == $past(lk[6]) && vidToHost == !$past(lk[6])) else $error("vid decision wrong");
  AST_VID_UNK: assert property (vidCheckValid && vlanEnable && vidInvalid && unknownVidFwdEnable |=>
    vidUnknownFwd && !vidDrop && !vidToHost) else $error("unknown vid forwarding lost");
  AST_AGE: assert property (dynEntryUpdate |=> ageLoadValid &&
    ageLoadValue == $past(lk[5:3])) else $error("age load wrong");
  AST_AGING: assert property ($past(rst_n) |->
    agingTime == $past(lk[5:3]) * $past(agePeriod)) else $error("aging time wrong");
  AST_HASH_DIRECT: assert property (lookupValid && lk[1:0] != 2'b01 && lk[1:0] != 2'b10 |=>
    indexValid && tableIndex == $past(destAddr[9:0])) else $error("direct index wrong");
  AST_HASH_CRC: assert property (lookupValid && lk[1:0] == 2'b01 |=>
    indexValid && tableIndex == crc($past(destAddr))) else $error("crc index wrong");
  AST_RSVD_ZERO: assert property (psel && penable && !pwrite && paddr == A_SH |->
    prdata == {30'h0, shp}) else $error("shaper readback wrong");
  cover property (vidCheckValid && vlanEnable && vidInvalid && unknownVidFwdEnable);
  cover property (lookupValid && lk[1:0] == 2'b10);
  cover property (wr && paddr == A_LK);
endmodule

bind switch_lookup_shaper_config switch_lookup_shaper_config_chk #(.LEN_W(LEN_W), .PERIOD_W(PERIOD_W)) u_chk (.*);

// ==== dv/tb_switch_lookup_shaper_config.sv ====
// Bench for the lookup config bank: APB access, charges, VID, aging, index
// Assumes header byte addresses and a single 200 MHz clock
`include "switch_lookup_cfg.svh"
module tb_switch_lookup_shaper_config
  import switch_lookup_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [13:0] A_SH = {`SLC_IDX_SHAPER, 2'b00};
  localparam logic [13:0] A_LK = {`SLC_IDX_LOOKUP0, 2'b00};
  localparam int OV = `SLC_IPG_BYTES + `SLC_PREAMBLE_BYTES;
  localparam logic [49:0] X = {2'b00, 48'hA5C3_3C5A_0F1E};
  logic clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [13:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat;
  logic [3:0] pstrb = '0;
  logic pready, pslverr, rerr, shapeFrameValid = 0, policeFrameValid = 0;
  logic vidCheckValid = 0, vidInvalid = 0, unknownVidFwdEnable = 0;
  logic dynEntryUpdate = 0, lookupValid = 0;
  logic [15:0] shapeFrameLen = '0, policeFrameLen = '0;
  logic [7:0] agePeriod = '0;
  mac_addr_t destAddr = '0;
  logic shapeChargeValid, policeChargeValid, vlanEnable, vidDecisionValid;
  logic vidDrop, vidToHost, vidUnknownFwd, ageLoadValid, rsvdMcastEnable, indexValid;
  logic [16:0] shapeCharge, policeCharge;
  logic [2:0] ageLoadValue;
  logic [10:0] agingTime;
  table_index_t tableIndex;
  int n_errors = 0, n_tests = 0;
  switch_lookup_shaper_config dut (.*);
  initial forever #2.5 clk_sys = ~clk_sys;
  task automatic close_out();
    $display("Counts: %0d checks, %0d mismatches", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hF;
    @(posedge clk_sys);
    penable <= 1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      n_errors++;
      close_out();
    end else begin
      rdat = prdata;
      rerr = pslverr;
      psel <= 0;
      penable <= 0;
    end
  endtask
  // Reference index hash built from the header constants
  function automatic table_index_t crcRef(input mac_addr_t a);
    table_index_t c;
    c = `SLC_CRC_INIT;
    for (int i = 47; i >= 0; i--) begin
      c = (c[9] ^ a[i]) ? ((c << 1) ^ `SLC_CRC_POLY) : (c << 1);
    end
    return c;
  endfunction
  task automatic charge(input logic [15:0] len, input int os, input int op);
    @(posedge clk_sys);
    shapeFrameValid <= 1;
    policeFrameValid <= 1;
    shapeFrameLen <= len;
    policeFrameLen <= len - 16'd1;
    @(posedge clk_sys);
    shapeFrameValid <= 0;
    policeFrameValid <= 0;
    #1 check({shapeChargeValid, policeChargeValid}, 2'b11);
    check(shapeCharge, len + os);
    check(policeCharge, len - 1 + op);
  endtask
  task automatic vid(input logic inv, input logic unk, input logic [2:0] e);
    @(posedge clk_sys);
    vidCheckValid <= 1;
    vidInvalid <= inv;
    unknownVidFwdEnable <= unk;
    @(posedge clk_sys);
    vidCheckValid <= 0;
    #1 check({vidDrop, vidToHost, vidUnknownFwd}, e);
    check(vidDecisionValid, 1);
  endtask
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_n <= 1;
    apb(0, A_SH, 0);
    check(rdat, 32'h3);
    apb(0, A_LK, 0);
    check(rdat, 32'h61);
    check({vlanEnable, rsvdMcastEnable}, 0);
    apb(1, A_SH, 32'hFFFF_FFFE);
    apb(0, A_SH, 0);
    check(rdat, 32'h2);
    apb(0, 14'h0FFC, 0);
    check(rerr, 1);
    check(rdat, 0);
    $display("Test registers done");
    charge(16'd64, OV, 0);
    apb(1, A_SH, 1);
    charge(16'hFFFF, 0, OV);
    $display("Test charges done");
    vid(1, 0, 3'b000);
    apb(1, A_LK, 32'hE1);
    #1 check(vlanEnable, 1);
    vid(1, 0, 3'b100);
    vid(1, 1, 3'b001);
    vid(0, 1, 3'b000);
    apb(1, A_LK, 32'hA1);
    vid(1, 0, 3'b010);
    vid(1, 1, 3'b001);
    $display("Test vid done");
    for (int a = 0; a < 8; a++) begin
      apb(1, A_LK, 32'(a << 3));
      agePeriod <= 8'(240 + a);
      @(posedge clk_sys);
      dynEntryUpdate <= 1;
      @(posedge clk_sys);
      dynEntryUpdate <= 0;
      #1 check({ageLoadValid, ageLoadValue}, {1'b1, a[2:0]});
      @(posedge clk_sys);
      #1 check(agingTime, a * (240 + a));
    end
    $display("Test aging done");
    destAddr <= X[47:0];
    for (int h = 0; h < 4; h++) begin
      apb(1, A_LK, 32'(h * 5));
      #1 check(rsvdMcastEnable, h[0]);
      @(posedge clk_sys);
      lookupValid <= 1;
      @(posedge clk_sys);
      lookupValid <= 0;
      #1 check(indexValid, 1);
      if (h == 2) check(tableIndex, X[9:0] ^ X[19:10] ^ X[29:20] ^ X[39:30] ^ X[49:40]);
      else if (h == 1) check(tableIndex, crcRef(X[47:0]));
      else check(tableIndex, X[9:0]);
    end
    $display("Test lookup done");
    close_out();
  end
endmodule
